// ### stream_directive_report.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Optimal write size at bytes 19:16
// - Write size clamped to maximum transfer size
// - Write size zero for all-namespaces, mixed blocks
// - Granularity at 21:20, zero for all-namespaces
// - Exclusive allocation count at bytes 23:22
// - Open limit: allocation count, else shared pool
// - Same-host open count at bytes 25:24
// - Other hosts' streams left out of same-host counts
// - Operation 02h selects status query
// - Status query ignores directive specific field
// - Status covers issuing host's namespace streams
// - All-namespaces status lists shared-resource streams
// - Open count at status bytes 01:00
// - Identifiers ascending from bytes 03:02
// - Status reply holds 65535 identifier entries
// - Shared pool count at bytes 3:2
// - Operation 01h selects parameter query
module stream_directive_report
  import stream_report_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Directive receive command
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic [31:0] namespace_selector_in,
  input wire logic [15:0] directive_specific_field_in,
  output logic cmd_reject_out,
  // Namespace and subsystem figures
  input wire logic [31:0] optimal_write_size_in,
  input wire logic [31:0] max_transfer_size_in,
  input wire logic single_block_size_in,
  input wire logic [15:0] granularity_size_in,
  input wire logic [15:0] ns_exclusive_alloc_count_in,
  input wire logic [15:0] max_streams_limit_in,
  input wire logic [15:0] shared_pool_available_in,
  // Stream open and close events
  input wire logic stream_open_in,
  input wire logic stream_close_in,
  input wire logic [15:0] stream_id_in,
  input wire logic [31:0] stream_ns_in,
  input wire logic stream_same_host_in,
  input wire logic stream_exclusive_in,
  input wire logic [15:0] stream_ns_alloc_in,
  output logic open_refused_out,
  // Reply word stream
  output logic reply_valid_out,
  input wire logic reply_ready_in,
  output logic [15:0] reply_data_out,
  output logic [15:0] reply_index_out,
  output logic reply_last_out
);

  // Stream table
  logic [SLOTS-1:0] open_q, open_d;
  logic [SLOTS-1:0] host_q, host_d;
  logic [SLOTS-1:0] excl_q, excl_d;
  logic [31:0] ns_q [SLOTS];
  logic [31:0] ns_d [SLOTS];
  logic refused_q, refused_d;

  // Reply engine
  state_type state_q, state_d;
  word_type image_q [PR_WORDS];
  word_type image_d [PR_WORDS];
  logic [SLOTS-1:0] match_q, match_d;
  logic [START_W-1:0] start_q, start_d;
  logic [15:0] idx_q, idx_d;
  word_type data_q, data_d;
  logic valid_q, valid_d;
  logic last_q, last_d;
  logic reject_q, reject_d;

  // Ascending identifier search
  scan_if scan ();

  stream_scan u_scan (
    .scan(scan.finder)
  );

  assign scan.match = match_q;
  assign scan.start = start_q;

  function automatic logic [15:0] count_bits(input logic [SLOTS-1:0] v);
    logic [15:0] sum;
    sum = '0;
    for (int i = 0; i < SLOTS; i++) begin
      sum = sum + 16'(v[i]);
    end
    return sum;
  endfunction : count_bits

  function automatic logic [SLOTS-1:0] ns_mask(input logic [31:0] ns);
    logic [SLOTS-1:0] m;
    m = '0;
    for (int i = 0; i < SLOTS; i++) begin
      m[i] = (ns_q[i] == ns);
    end
    return m;
  endfunction : ns_mask

  // Stream table updates
  always_comb begin
    logic [SLOT_W-1:0] slot;
    logic in_range;
    logic [15:0] ns_open;
    logic [15:0] shared_open;
    slot = stream_id_in[SLOT_W-1:0];
    in_range = (stream_id_in != 16'h0000) && (stream_id_in < 16'(SLOTS));
    ns_open = count_bits(open_q & host_q & ns_mask(stream_ns_in));
    shared_open = count_bits(open_q & ~excl_q);
    open_d = open_q;
    host_d = host_q;
    excl_d = excl_q;
    ns_d = ns_q;
    refused_d = 1'b0;
    // Close wins over an open in the same cycle
    if (stream_close_in && in_range) begin
      open_d[slot] = 1'b0;
    end else if (stream_open_in) begin
      if (!in_range) begin
        refused_d = 1'b1;
      end else if (!open_q[slot]) begin
        if ((stream_ns_alloc_in != 16'h0000) ? (ns_open >= stream_ns_alloc_in)
            : (shared_open >= shared_pool_available_in)) begin
          refused_d = 1'b1;
        end else begin
          open_d[slot] = 1'b1;
          host_d[slot] = stream_same_host_in;
          excl_d[slot] = stream_exclusive_in && (stream_ns_alloc_in != 16'h0000);
          ns_d[slot] = stream_ns_in;
        end
      end
    end
  end

  // Command decode and reply sequencing
  always_comb begin
    logic all_ns;
    logic [31:0] write_size;
    all_ns = (namespace_selector_in == NS_ALL);
    write_size = (optimal_write_size_in > max_transfer_size_in) ? max_transfer_size_in : optimal_write_size_in;
    state_d = state_q;
    image_d = image_q;
    match_d = match_q;
    start_d = start_q;
    idx_d = idx_q;
    data_d = data_q;
    valid_d = valid_q;
    last_d = last_q;
    reject_d = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (cmd_valid_in) begin
          idx_d = '0;
          last_d = 1'b0;
          case (cmd_opcode_in)
            OP_PARAMS: begin
              for (int w = 0; w < PR_WORDS; w++) begin
                image_d[w] = '0;
              end
              image_d[PR_LIMIT_BYTE / WORD_BYTES] = max_streams_limit_in;
              image_d[PR_POOL_BYTE / WORD_BYTES] = shared_pool_available_in;
              image_d[PR_SHARED_OPEN_BYTE / WORD_BYTES] = count_bits(open_q & ~excl_q);
              if (!all_ns || single_block_size_in) begin
                image_d[PR_WRITE_SIZE_BYTE / WORD_BYTES] = write_size[15:0];
                image_d[PR_WRITE_SIZE_BYTE / WORD_BYTES + 1] = write_size[31:16];
              end
              if (!all_ns) begin
                image_d[PR_GRAN_BYTE / WORD_BYTES] = granularity_size_in;
                image_d[PR_ALLOC_BYTE / WORD_BYTES] = ns_exclusive_alloc_count_in;
                // Same-host open count, own host only
                image_d[PR_OPEN_BYTE / WORD_BYTES] = count_bits(open_q & host_q & ns_mask(namespace_selector_in));
              end
              data_d = image_d[0];
              valid_d = 1'b1;
              state_d = S_PARAM;
            end
            // Status query decode, specific field unused
            OP_STATUS: begin
              // Matching set frozen until the reply ends
              if (all_ns) begin
                match_d = open_q & ~excl_q;
              end else begin
                match_d = open_q & host_q & ns_mask(namespace_selector_in);
              end
              start_d = '0;
              data_d = count_bits(match_d);
              valid_d = 1'b1;
              state_d = S_STATUS;
            end
            default: begin
              reject_d = 1'b1;
            end
          endcase
        end
      end
      // One word per accepted handshake
      S_PARAM, S_STATUS: begin
        if (reply_ready_in) begin
          if (last_q) begin
            valid_d = 1'b0;
            state_d = S_IDLE;
          end else begin
            idx_d = idx_q + 16'h0001;
            if (state_q == S_PARAM) begin
              data_d = image_q[idx_d[3:0]];
              last_d = (idx_d == PR_LAST_WORD);
            end else begin
              if (scan.found && idx_d >= ST_FIRST_ID_WORD) begin
                data_d = 16'(scan.index);
                start_d = START_W'(scan.index) + START_W'(1);
              end else begin
                data_d = '0;
              end
              last_d = (idx_d == ST_LAST_WORD);
            end
          end
        end
      end
      default: begin
        valid_d = 1'b0;
        state_d = S_IDLE;
      end
    endcase
  end

  // Stream table registers
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      open_q <= '0;
      host_q <= '0;
      excl_q <= '0;
      ns_q <= '{default: '0};
      refused_q <= 1'b0;
    end else begin
      open_q <= open_d;
      host_q <= host_d;
      excl_q <= excl_d;
      ns_q <= ns_d;
      refused_q <= refused_d;
    end
  end

  // Reply engine registers
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_q <= S_IDLE;
      image_q <= '{default: '0};
      match_q <= '0;
      start_q <= '0;
      idx_q <= '0;
      data_q <= '0;
      valid_q <= 1'b0;
      last_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      state_q <= state_d;
      image_q <= image_d;
      match_q <= match_d;
      start_q <= start_d;
      idx_q <= idx_d;
      data_q <= data_d;
      valid_q <= valid_d;
      last_q <= last_d;
      reject_q <= reject_d;
    end
  end

  // Command ready decoded from state, other outputs straight from registers
  assign cmd_ready_out = (state_q == S_IDLE);
  assign cmd_reject_out = reject_q;
  assign open_refused_out = refused_q;
  assign reply_valid_out = valid_q;
  assign reply_data_out = data_q;
  assign reply_index_out = idx_q;
  assign reply_last_out = last_q;

endmodule : stream_directive_report
`default_nettype wire

// ### stream_report_pkg.sv
`default_nettype none
package stream_report_pkg;

  // Stream table: slot index equals stream identifier, slot 0 never opens
  localparam int SLOTS = 32;
  localparam int SLOT_W = 5;
  localparam int START_W = 6;

  // Directive operations on directive receive for streams
  localparam logic [7:0] OP_PARAMS = 8'h01;
  localparam logic [7:0] OP_STATUS = 8'h02;

  // Selector naming every namespace
  localparam logic [31:0] NS_ALL = 32'hffffffff;

  // Parameter reply byte offsets
  localparam int PR_LIMIT_BYTE = 0;
  localparam int PR_POOL_BYTE = 2;
  localparam int PR_SHARED_OPEN_BYTE = 4;
  localparam int PR_WRITE_SIZE_BYTE = 16;
  localparam int PR_GRAN_BYTE = 20;
  localparam int PR_ALLOC_BYTE = 22;
  localparam int PR_OPEN_BYTE = 24;
  localparam int PR_BYTES = 32;

  // Status reply byte offsets
  localparam int ST_COUNT_BYTE = 0;
  localparam int ST_ID_BYTE = 2;
  localparam int ST_LAST_BYTE = 131070;

  // Reply travels as little-endian 16-bit words
  localparam int WORD_BYTES = 2;
  localparam int PR_WORDS = PR_BYTES / WORD_BYTES;
  localparam logic [15:0] PR_LAST_WORD = 16'(PR_WORDS - 1);
  localparam logic [15:0] ST_FIRST_ID_WORD = 16'(ST_ID_BYTE / WORD_BYTES);
  localparam logic [15:0] ST_LAST_WORD = 16'(ST_LAST_BYTE / WORD_BYTES);

  typedef logic [15:0] word_type;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_PARAM = 2'b01,
    S_STATUS = 2'b11
  } state_type;

endpackage : stream_report_pkg
`default_nettype wire

// ### scan_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scan_if;
  import stream_report_pkg::*;

  logic [SLOTS-1:0] match;
  logic [START_W-1:0] start;
  logic found;
  logic [SLOT_W-1:0] index;

  modport requester (output match, output start, input found, input index);
  modport finder (input match, input start, output found, output index);

endinterface : scan_if
`default_nettype wire

// ### stream_scan.sv
`timescale 1ns/1ps
`default_nettype none
module stream_scan
  import stream_report_pkg::*;
(
  // Search request and result
  scan_if.finder scan
);

  // Lowest matching slot at or above the start point
  always_comb begin
    scan.found = 1'b0;
    scan.index = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (scan.match[i] && (START_W'(i) >= scan.start)) begin
        scan.found = 1'b1;
        scan.index = SLOT_W'(i);
      end
    end
  end

endmodule : stream_scan
`default_nettype wire

// ### stream_directive_report_chk.sv
`timescale 1ns/1ps
`default_nettype none
module stream_directive_report_chk
  import stream_report_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  // Command and stream events
  input wire logic cmd_valid_in,
  input wire logic cmd_ready_out,
  input wire logic [7:0] cmd_opcode_in,
  input wire logic cmd_reject_out,
  input wire logic stream_open_in,
  input wire logic stream_close_in,
  input wire logic [15:0] stream_id_in,
  input wire logic open_refused_out,
  // Reply word stream
  input wire logic reply_valid_out,
  input wire logic reply_ready_in,
  input wire logic [15:0] reply_data_out,
  input wire logic [15:0] reply_index_out,
  input wire logic reply_last_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  wire logic take = cmd_valid_in && cmd_ready_out;
  wire logic step = reply_valid_out && reply_ready_in;

  chk_reject_bad_op: assert property (take && cmd_opcode_in != OP_PARAMS && cmd_opcode_in != OP_STATUS
    |=> cmd_reject_out && !reply_valid_out) else $error("unknown operation not rejected");
  chk_param_start: assert property (take && cmd_opcode_in == OP_PARAMS
    |=> reply_valid_out && reply_index_out == 16'h0000 && !cmd_reject_out) else $error("parameter reply missing");
  chk_status_start: assert property (take && cmd_opcode_in == OP_STATUS
    |=> reply_valid_out && reply_index_out == 16'h0000 && !cmd_reject_out) else $error("status reply missing");
  chk_busy_no_cmd: assert property (reply_valid_out |-> !cmd_ready_out) else $error("command open mid reply");
  chk_word_hold: assert property (reply_valid_out && !reply_ready_in
    |=> reply_valid_out && $stable(reply_data_out) && $stable(reply_index_out)) else $error("word not held");
  chk_index_step: assert property (step && !reply_last_out
    |=> reply_valid_out && reply_index_out == $past(reply_index_out) + 16'h0001) else $error("index skipped");
  chk_last_index: assert property (reply_valid_out && reply_last_out
    |-> reply_index_out == PR_LAST_WORD || reply_index_out == ST_LAST_WORD) else $error("wrong last word");
  chk_last_release: assert property (step && reply_last_out |=> !reply_valid_out && cmd_ready_out)
    else $error("reply not released");
  chk_id_zero_refused: assert property (stream_open_in && !stream_close_in && stream_id_in == 16'h0000
    |=> open_refused_out) else $error("identifier zero accepted");

  cov_param: cover property (take && cmd_opcode_in == OP_PARAMS);
  cov_status: cover property (take && cmd_opcode_in == OP_STATUS);
  cov_reject: cover property (cmd_reject_out);
  cov_refused: cover property (open_refused_out);
endmodule : stream_directive_report_chk
bind stream_directive_report stream_directive_report_chk chk_i (.*);
`default_nettype wire

// ### host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model
  import stream_report_pkg::*;
(
  // Clock
  input wire logic ref_clk_in,
  // Command
  output logic cmd_valid_out = 1'b0,
  input wire logic cmd_ready_in,
  output logic [7:0] cmd_opcode_out = 8'h00,
  output logic [31:0] ns_out = 32'h0000_0000,
  output logic [15:0] specific_out = 16'h0000,
  input wire logic cmd_reject_in,
  // Reply
  input wire logic reply_valid_in,
  output logic reply_ready_out = 1'b0,
  input wire logic [15:0] reply_data_in,
  input wire logic [15:0] reply_index_in,
  input wire logic reply_last_in
);
  word_type w [64];
  int nwords;
  int tail_bad;
  logic rej;
  logic [15:0] last_idx;

  // Stops early after max_words words when max_words is non-zero
  task automatic query(input logic [7:0] op, input logic [31:0] ns, input logic [15:0] ds,
      input bit slow, input int max_words);
    bit done;
    @(negedge ref_clk_in);
    cmd_valid_out = 1'b1;
    cmd_opcode_out = op;
    ns_out = ns;
    specific_out = ds;
    @(negedge ref_clk_in);
    cmd_valid_out = 1'b0;
    cmd_opcode_out = ~op;
    ns_out = ~ns;
    rej = cmd_reject_in;
    done = rej;
    nwords = 0;
    tail_bad = 0;
    while (!done) begin
      reply_ready_out = slow ? !reply_ready_out : 1'b1;
      if (reply_valid_in && reply_ready_out) begin
        if (nwords < 64) w[nwords] = reply_data_in;
        else if (reply_data_in !== 16'h0000) tail_bad++;
        last_idx = reply_index_in;
        nwords++;
        done = reply_last_in || nwords == max_words;
      end
      @(negedge ref_clk_in);
    end
    reply_ready_out = 1'b0;
  endtask : query
endmodule : host_model
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import stream_report_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic cmd_valid_in, cmd_ready_out, cmd_reject_out, single_block_size_in, stream_open_in, stream_close_in;
  logic stream_same_host_in, stream_exclusive_in, open_refused_out, reply_valid_out, reply_ready_in;
  logic reply_last_out;
  logic [7:0] cmd_opcode_in;
  logic [31:0] namespace_selector_in, optimal_write_size_in, max_transfer_size_in, stream_ns_in;
  logic [15:0] directive_specific_field_in, granularity_size_in, ns_exclusive_alloc_count_in;
  logic [15:0] max_streams_limit_in, shared_pool_available_in, stream_id_in, stream_ns_alloc_in;
  logic [15:0] reply_data_out, reply_index_out;
  logic [7:0] bad_ops [3] = '{8'h00, 8'h03, 8'hff};
  word_type exp_w [16];
  int bad_count = 0;
  int compares = 0;
  int cyc = 0;

  always #12.5 ref_clk_in = ~ref_clk_in;
  stream_directive_report dut (.*);
  host_model host (.ref_clk_in, .cmd_valid_out(cmd_valid_in), .cmd_ready_in(cmd_ready_out),
    .cmd_opcode_out(cmd_opcode_in), .ns_out(namespace_selector_in), .specific_out(directive_specific_field_in),
    .cmd_reject_in(cmd_reject_out), .reply_valid_in(reply_valid_out), .reply_ready_out(reply_ready_in),
    .reply_data_in(reply_data_out), .reply_index_in(reply_index_out), .reply_last_in(reply_last_out));

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Exclusive streams live in namespace 1, shared ones in namespace 2
  task automatic ev(input logic cl, input logic [15:0] id, input logic same, input logic excl, input logic exp_ref);
    @(negedge ref_clk_in);
    stream_open_in = 1'b1;
    stream_close_in = cl;
    stream_id_in = id;
    stream_ns_in = excl ? 32'h0000_0001 : 32'h0000_0002;
    stream_same_host_in = same;
    stream_exclusive_in = excl;
    stream_ns_alloc_in = excl ? 16'h0002 : 16'h0000;
    @(negedge ref_clk_in);
    stream_open_in = 1'b0;
    stream_close_in = 1'b0;
    check(open_refused_out, exp_ref, "refused");
  endtask : ev

  task automatic param(input logic [31:0] ns, input logic [15:0] e2, e8, e10, e11, e12);
    host.query(OP_PARAMS, ns, 16'h5a5a, 1'b1, 0);
    exp_w = '{default: 16'h0000};
    exp_w[0] = 16'h0010;
    exp_w[1] = 16'h0003;
    exp_w[2] = e2;
    exp_w[8] = e8;
    exp_w[10] = e10;
    exp_w[11] = e11;
    exp_w[12] = e12;
    check(host.nwords, 16, "param words");
    for (int i = 0; i < 16; i++)
      check(host.w[i], exp_w[i], "param word");
    $display("test param %h done", ns);
  endtask : param

  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      give_verdict();
    end
  end

  initial begin
    {stream_open_in, stream_close_in, stream_same_host_in, stream_exclusive_in} = 4'h0;
    stream_id_in = 16'h0000;
    stream_ns_in = 32'h0000_0000;
    stream_ns_alloc_in = 16'h0000;
    single_block_size_in = 1'b1;
    optimal_write_size_in = 32'h0000_0040;
    max_transfer_size_in = 32'h0000_0030;
    granularity_size_in = 16'h0007;
    ns_exclusive_alloc_count_in = 16'h0002;
    max_streams_limit_in = 16'h0010;
    shared_pool_available_in = 16'h0003;
    repeat (12) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    ev(1'b0, 16'h0007, 1'b0, 1'b1, 1'b0);
    ev(1'b0, 16'h0005, 1'b1, 1'b1, 1'b0);
    ev(1'b0, 16'h0002, 1'b1, 1'b1, 1'b0);
    ev(1'b0, 16'h0009, 1'b1, 1'b1, 1'b1);
    ev(1'b0, 16'h000b, 1'b1, 1'b0, 1'b0);
    ev(1'b0, 16'h0004, 1'b0, 1'b0, 1'b0);
    ev(1'b0, 16'h000a, 1'b1, 1'b0, 1'b0);
    ev(1'b0, 16'h000c, 1'b1, 1'b0, 1'b1);
    ev(1'b0, 16'h0000, 1'b1, 1'b0, 1'b1);
    $display("test streams done");
    param(32'h0000_0001, 16'h0003, 16'h0030, 16'h0007, 16'h0002, 16'h0002);
    single_block_size_in = 1'b0;
    param(NS_ALL, 16'h0003, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    foreach (bad_ops[i]) begin
      host.query(bad_ops[i], 32'h0000_0001, 16'h0000, 1'b0, 0);
      check(host.rej, 1'b1, "reject");
    end
    $display("test reject done");
    ev(1'b1, 16'h0005, 1'b1, 1'b1, 1'b0);
    host.query(OP_STATUS, 32'h0000_0001, 16'hffff, 1'b0, 0);
    check(host.nwords, 32'h0001_0000, "status words");
    check(host.last_idx, 16'hffff, "last index");
    check(host.w[0], 16'h0001, "count");
    check(host.w[1], 16'h0002, "id");
    check(host.w[2], 16'h0000, "pad");
    check(host.tail_bad, 0, "tail");
    $display("test status done");
    host.query(OP_STATUS, NS_ALL, 16'h0000, 1'b1, 5);
    exp_w[0] = 16'h0003;
    exp_w[1] = 16'h0004;
    exp_w[2] = 16'h000a;
    exp_w[3] = 16'h000b;
    exp_w[4] = 16'h0000;
    for (int i = 0; i < 5; i++)
      check(host.w[i], exp_w[i], "all status");
    rstn_in = 1'b0;
    #1;
    check(reply_valid_out, 1'b0, "reset abort");
    check(cmd_ready_out, 1'b1, "reset ready");
    @(negedge ref_clk_in);
    rstn_in = 1'b1;
    max_transfer_size_in = 32'h0000_0100;
    param(32'h0000_0001, 16'h0000, 16'h0040, 16'h0007, 16'h0002, 16'h0000);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
